// file: fcp_pkg.sv
package fcp_pkg;
    // status word bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_SIGN = 6;
    localparam int ST_ZERO = 5;
    localparam int ST_DIVX = 3;
    localparam int ST_UNDF = 2;
    localparam int ST_OVFL = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // command byte layout and opcodes
    localparam int CMD_SRQ_EN = 7;
    localparam logic [6:0] OPC_CLEAR = 7'h00;
    localparam logic [6:0] OPC_SADD  = 7'h01;
    localparam logic [6:0] OPC_SDIV  = 7'h04;
    localparam logic [6:0] OPC_DADD  = 7'h29;
    localparam logic [6:0] OPC_DDIV  = 7'h2c;
    localparam logic [2:0] OP_ADD    = 3'h1;
    localparam logic [2:0] OP_SUB    = 3'h2;
    localparam logic [2:0] OP_MUL    = 3'h3;
    localparam logic [2:0] OP_DIV    = 3'h4;

    // operand stack: 16 bytes = 4 single or 2 double quantities
    localparam int STACK_BYTES = 16;
    localparam logic [3:0] SIZE_SGL = 4'h4;
    localparam logic [3:0] SIZE_DBL = 4'h8;

    // number formats
    localparam int SGL_SIGN = 31;
    localparam int SGL_EXP_LO = 23;
    localparam int SGL_EXP_HI = 30;
    localparam int DBL_SIGN = 63;
    localparam int DBL_EXP_LO = 52;
    localparam int DBL_EXP_HI = 62;
    localparam logic signed [12:0] SGL_BIAS = 13'sh007f;
    localparam logic signed [12:0] DBL_BIAS = 13'sh03ff;
    // a zero operand gets an exponent far below any real one
    localparam logic signed [12:0] ZERO_EXP = -13'sh07d0;
    // internal mantissa: hidden one at bit 62, bit 63 is carry headroom
    localparam int MAN_HID = 62;
    localparam int SGL_FRAC_LO = 39;
    localparam int DBL_FRAC_LO = 10;
    localparam logic signed [12:0] MUL_EXP_ADJ = 13'sh0002;
    localparam logic signed [12:0] DIV_EXP_ADJ = 13'sh0001;
    localparam logic [6:0] ITER_LAST = 7'h3f;
endpackage

// file: fcp_host_port.sv
// Function
// [RULE1] write with C/D high takes a command
// [RULE2] pause follows chip select while strobes idle
// [RULE3] raise pause to acknowledge; host then releases
// [RULE4] new command waits while previous one runs
// [RULE5] data write pushes byte, low byte first
// [RULE6] host pushes four or eight bytes each
// [RULE7] stack holds 16 bytes, overwriting oldest
// [RULE8] data read pops top byte, high first
// [RULE9] read acknowledged once byte driven, held
// [RULE10] reads move pointer only, wrapping around
// [RULE11] status read answered at any time
// [RULE12] status bit layout busy sign zero flags
// [RULE13] status zero after reset and clear command
// [RULE14] command sets busy, clears other bits
// [RULE15] divide flag only on divide by zero
// [RULE16] zero and sign flags follow result
// [RULE17] single format sign, 8-bit exponent, mantissa
// [RULE18] double format sign, 11-bit exponent, mantissa
// [RULE19] restore hidden bit, normalize, strip it
// [RULE20] operands from top and next, result popped
// [RULE21] low seven bits opcode, bit 7 request
// [RULE22] opcode map for clear and arithmetic
// [RULE23] sample pins synchronously, pause low one clock
`timescale 1ns/1ps
module fcp_host_port
    import fcp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       csN,
    input  wire logic       rdN,
    input  wire logic       wrN,
    input  wire logic       cmdData,
    input  wire logic [7:0] hostDataBusIn,
    output logic      [7:0] hostDataBusOut,
    output logic            hostDataBusOe,
    output logic            pauseN,
    output logic            serviceRequest
);
    typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} fcp_bus_t;
    typedef enum logic [2:0] {ENG_IDLE, ENG_PREP, ENG_ITER, ENG_NORM, ENG_WRITE} fcp_eng_t;

    // pin synchronisers: first stage feeds only the second
    logic [11:0] pinMeta_reg;
    logic [11:0] pinSync_reg;
    always_ff @(posedge clk) begin
        if (ce) begin
            pinMeta_reg <= {csN, rdN, wrN, cmdData, hostDataBusIn}; // RULE23
            pinSync_reg <= pinMeta_reg;
        end
    end
    wire       csS   = pinSync_reg[11];
    wire       rdS   = pinSync_reg[10];
    wire       wrS   = pinSync_reg[9];
    wire       cdS   = pinSync_reg[8];
    wire [7:0] dinS  = pinSync_reg[7:0];

    fcp_bus_t    bus_reg;
    fcp_eng_t    eng_reg;
    logic [7:0]  stack_reg [STACK_BYTES];
    logic [3:0]  ptr_reg;
    logic [7:0]  status_reg;
    logic [7:0]  dout_reg;
    logic        doe_reg;
    logic        pause_reg;
    logic        srq_reg;
    logic [7:0]  cmd_reg;
    logic        sA_reg, sB_reg, rs_reg;
    logic signed [12:0] eA_reg, eB_reg, re_reg;
    logic [63:0] mA_reg, mB_reg, rm_reg;
    logic [64:0] rem_reg;
    logic [6:0]  cnt_reg;

    // bus request decode; data and command traffic wait for an idle engine
    wire wrReq   = !csS && !wrS;
    wire rdReq   = !csS && !rdS && wrS;
    wire engIdle = (eng_reg == ENG_IDLE);
    wire needEng = wrReq || (rdReq && !cdS);
    wire go      = (bus_reg == BUS_IDLE) && (wrReq || rdReq) && (!needEng || engIdle); // RULE4
    wire cmdTake = go && wrReq && cdS;  // RULE1
    wire push    = go && wrReq && !cdS; // RULE5
    wire pop     = go && rdReq && !cdS; // RULE8
    wire stRead  = go && rdReq && cdS;  // RULE11
    wire [3:0] ptrDec = ptr_reg - 4'h1;
    wire [7:0] popByte = stack_reg[ptrDec];

    // operand fetch: top occupies the last size bytes, next the size before
    wire       cmdDbl  = dinS[5];
    wire [3:0] sizeNew = cmdDbl ? SIZE_DBL : SIZE_SGL;
    wire [3:0] sizeCur = cmd_reg[5] ? SIZE_DBL : SIZE_SGL;
    wire [3:0] tosBase = ptr_reg - sizeNew; // RULE20
    wire [3:0] nosBase = ptr_reg - {sizeNew[2:0], 1'b0};
    wire [3:0] resBase = ptr_reg - {sizeCur[2:0], 1'b0};
    wire [63:0] tosVal;
    wire [63:0] nosVal;
    for (genvar k = 0; k < 8; k++) begin : g_fetch
        assign tosVal[k*8 +: 8] = stack_reg[4'(tosBase + 4'(k))];
        assign nosVal[k*8 +: 8] = stack_reg[4'(nosBase + 4'(k))];
    end

    // unpack: restore the hidden one at a common position for both formats
    function automatic logic [77:0] unpack(input logic [63:0] v, input logic dbl);
        logic        s;
        logic [10:0] e;
        logic [63:0] m;
        s = dbl ? v[DBL_SIGN] : v[SGL_SIGN];                             // RULE17 RULE18
        e = dbl ? v[DBL_EXP_HI:DBL_EXP_LO] : {3'h0, v[SGL_EXP_HI:SGL_EXP_LO]};
        m = dbl ? {2'b01, v[DBL_EXP_LO-1:0], 10'h000}
                : {2'b01, v[SGL_EXP_LO-1:0], 39'h0};                     // RULE19
        if (e == 11'h000) begin
            return {s, ZERO_EXP, 64'h0};
        end
        return {s, 13'(e) - (dbl ? DBL_BIAS : SGL_BIAS), m};
    endfunction
    wire [77:0] upA = unpack(nosVal, cmdDbl);
    wire [77:0] upB = unpack(tosVal, cmdDbl);

    // pack: strip the hidden one and rebias; zero mantissa packs to zero
    wire signed [12:0] bias   = cmd_reg[5] ? DBL_BIAS : SGL_BIAS;
    wire signed [12:0] expOut = re_reg + bias;
    wire [63:0] packWord = (rm_reg == 64'h0) ? 64'h0 :
        cmd_reg[5] ? {rs_reg, expOut[10:0], rm_reg[MAN_HID-1:DBL_FRAC_LO]}
                   : {32'h0, rs_reg, expOut[7:0], rm_reg[MAN_HID-1:SGL_FRAC_LO]}; // RULE19
    wire ovfl = (rm_reg != 64'h0) && (re_reg > bias);
    wire undf = (rm_reg != 64'h0) && (re_reg < 13'sh0001 - bias);

    // add/subtract alignment of the smaller operand
    wire signed [12:0] eDiff  = eA_reg - eB_reg;
    wire               aBig   = !eDiff[12];
    wire [12:0]        shAmt  = aBig ? eDiff : -eDiff;
    wire [63:0]        mBig   = aBig ? mA_reg : mB_reg;
    wire [63:0]        mSm    = (aBig ? mB_reg : mA_reg) >> shAmt;
    wire               sBig   = aBig ? sA_reg : sB_reg;
    wire               sSm    = aBig ? sB_reg : sA_reg;
    wire               bigGe  = (mBig >= mSm);
    wire [63:0]        addMag = (sBig == sSm) ? mBig + mSm : (bigGe ? mBig - mSm : mSm - mBig);
    wire               addSgn = (sBig == sSm || bigGe) ? sBig : sSm;

    // one step of shift-add multiply and restoring divide
    wire [64:0] mulSum  = {1'b0, rm_reg} + (mB_reg[cnt_reg[5:0]] ? {1'b0, mA_reg} : 65'h0);
    wire        divFits = (rem_reg >= {1'b0, mB_reg});
    wire [64:0] remSub  = divFits ? rem_reg - {1'b0, mB_reg} : rem_reg;
    wire [2:0]  opSel   = cmd_reg[2:0];
    wire        divPrep = (eng_reg == ENG_PREP) && (opSel == OP_DIV);
    wire        arith   = (cmd_reg[6:0] >= OPC_SADD && cmd_reg[6:0] <= OPC_SDIV)
                       || (cmd_reg[6:0] >= OPC_DADD && cmd_reg[6:0] <= OPC_DDIV); // RULE22

    // handshake: pause follows cs while idle, high once request is served
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_reg   <= BUS_IDLE;
            pause_reg <= 1'b1;
            doe_reg   <= 1'b0;
            dout_reg  <= 8'h00;
        end else if (ce) begin
            case (bus_reg)
                BUS_IDLE: begin
                    pause_reg <= (wrReq || rdReq) ? 1'b0 : csS; // RULE2 RULE4
                    if (go) begin
                        bus_reg <= BUS_ACK;
                        doe_reg <= rdReq;                        // RULE9
                        if (stRead) begin
                            dout_reg <= status_reg;              // RULE11
                        end else if (pop) begin
                            dout_reg <= stack_reg[ptrDec];       // RULE8
                        end
                    end
                end
                BUS_ACK: begin
                    pause_reg <= 1'b1;                           // RULE3 RULE23
                    if (wrS && rdS) begin
                        bus_reg <= BUS_IDLE;
                        doe_reg <= 1'b0;
                    end
                end
                default: bus_reg <= BUS_IDLE;
            endcase
        end
    end

    // stack storage; bus and engine never touch it in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            ptr_reg <= 4'h0;
        end else if (ce) begin
            if (push) begin
                stack_reg[ptr_reg] <= dinS;  // RULE5 RULE7
                ptr_reg            <= ptr_reg + 4'h1;
            end else if (pop) begin
                ptr_reg <= ptrDec;           // RULE10
            end else if (eng_reg == ENG_WRITE) begin
                for (int i = 0; i < STACK_BYTES; i++) begin
                    if (4'(4'(i) - resBase) < sizeCur) begin
                        stack_reg[i] <= packWord[8*(4'(4'(i) - resBase)) +: 8]; // RULE20
                    end
                end
                ptr_reg <= ptr_reg - sizeCur; // RULE20
            end
        end
    end

    // command engine
    always_ff @(posedge clk) begin
        if (srst) begin
            eng_reg    <= ENG_IDLE;
            status_reg <= STATUS_RESET; // RULE13
            srq_reg    <= 1'b0;
            cmd_reg    <= 8'h00;
            cnt_reg    <= 7'h00;
        end else if (ce) begin
            case (eng_reg)
                ENG_IDLE: begin
                    if (cmdTake) begin
                        cmd_reg    <= dinS;
                        status_reg <= 8'h00;
                        status_reg[ST_BUSY] <= 1'b1; // RULE14
                        srq_reg    <= 1'b0;
                        {sA_reg, eA_reg, mA_reg} <= upA;
                        {sB_reg, eB_reg, mB_reg} <= upB;
                        eng_reg    <= ENG_PREP;
                    end
                end
                ENG_PREP: begin
                    cnt_reg <= 7'h00;
                    rs_reg  <= sA_reg ^ sB_reg;
                    rm_reg  <= 64'h0;
                    rem_reg <= {1'b0, mA_reg};
                    if (!arith) begin
                        status_reg <= 8'h00;                          // RULE13
                        srq_reg    <= cmd_reg[CMD_SRQ_EN];            // RULE21
                        eng_reg    <= ENG_IDLE;
                    end else if (opSel == OP_ADD || opSel == OP_SUB) begin
                        rm_reg  <= addMag;
                        rs_reg  <= (opSel == OP_SUB) ? (aBig ? sA_reg : !sB_reg) ^
                                   ((sA_reg != !sB_reg) && !bigGe && aBig) ^
                                   ((sA_reg != !sB_reg) && bigGe && !aBig) : addSgn;
                        re_reg  <= aBig ? eA_reg : eB_reg;
                        eng_reg <= ENG_NORM;
                        if (opSel == OP_SUB) begin
                            sB_reg  <= !sB_reg;                        // subtract negates top
                            eng_reg <= ENG_PREP;
                            cmd_reg[2:0] <= OP_ADD;
                        end
                    end else if (opSel == OP_DIV && mB_reg == 64'h0) begin
                        status_reg[ST_DIVX] <= 1'b1;                   // RULE15
                        status_reg[ST_BUSY] <= 1'b0;
                        srq_reg <= cmd_reg[CMD_SRQ_EN];
                        eng_reg <= ENG_IDLE;
                    end else begin
                        re_reg  <= (opSel == OP_MUL) ? eA_reg + eB_reg + MUL_EXP_ADJ
                                                     : eA_reg - eB_reg - DIV_EXP_ADJ;
                        eng_reg <= (mA_reg == 64'h0) ? ENG_NORM : ENG_ITER;
                    end
                end
                ENG_ITER: begin
                    cnt_reg <= cnt_reg + 7'h01;
                    if (opSel == OP_MUL) begin
                        rm_reg <= mulSum[64:1];
                    end else begin
                        rm_reg  <= {rm_reg[62:0], divFits};
                        rem_reg <= {remSub[63:0], 1'b0};
                    end
                    if (cnt_reg == ITER_LAST) begin
                        eng_reg <= ENG_NORM;
                    end
                end
                ENG_NORM: begin
                    if (rm_reg == 64'h0) begin
                        eng_reg <= ENG_WRITE;
                    end else if (rm_reg[MAN_HID+1]) begin
                        rm_reg <= {1'b0, rm_reg[63:1]};                // RULE19
                        re_reg <= re_reg + 13'sh0001;
                    end else if (!rm_reg[MAN_HID]) begin
                        rm_reg <= {rm_reg[62:0], 1'b0};
                        re_reg <= re_reg - 13'sh0001;
                    end else begin
                        eng_reg <= ENG_WRITE;
                    end
                end
                ENG_WRITE: begin
                    status_reg[ST_BUSY] <= 1'b0;                       // RULE14
                    status_reg[ST_ZERO] <= (rm_reg == 64'h0);          // RULE16
                    status_reg[ST_SIGN] <= (rm_reg != 64'h0) && rs_reg;
                    status_reg[ST_OVFL] <= ovfl;                       // RULE12
                    status_reg[ST_UNDF] <= undf;
                    srq_reg <= cmd_reg[CMD_SRQ_EN];                    // RULE21
                    eng_reg <= ENG_IDLE;
                end
                default: eng_reg <= ENG_IDLE;
            endcase
        end
    end

    assign hostDataBusOut = dout_reg;
    assign hostDataBusOe  = doe_reg;
    assign pauseN         = pause_reg;
    assign serviceRequest = srq_reg;

    a_pause_follows: assert property (@(posedge clk) disable iff (srst) // RULE2
        (ce && bus_reg == BUS_IDLE && wrS && rdS) |=> (pause_reg == $past(csS)))
        else $error("pause does not follow chip select");
    a_write_ack: assert property (@(posedge clk) disable iff (srst) // RULE3
        (ce && go && wrReq) ##1 ce |=> pause_reg)
        else $error("write not acknowledged");
    a_busy_hold: assert property (@(posedge clk) disable iff (srst) // RULE4
        (ce && bus_reg == BUS_IDLE && wrReq && cdS && !engIdle) |=> !pause_reg)
        else $error("command acknowledged while busy");
    a_push_ptr: assert property (@(posedge clk) disable iff (srst) // RULE5
        (ce && push) |=> (ptr_reg == $past(ptr_reg) + 4'h1))
        else $error("push pointer wrong");
    a_pop_ptr: assert property (@(posedge clk) disable iff (srst) // RULE10
        (ce && pop) |=> (ptr_reg == $past(ptrDec)) && (dout_reg == $past(popByte)))
        else $error("pop pointer or byte wrong");
    a_read_drive: assert property (@(posedge clk) disable iff (srst) // RULE9
        (bus_reg == BUS_ACK && pause_reg && !rdS) |-> doe_reg)
        else $error("read byte not driven");
    a_cmd_busy: assert property (@(posedge clk) disable iff (srst) // RULE14
        (ce && cmdTake) |=> (status_reg == 8'h80))
        else $error("busy not set on command");
    a_div_flag: assert property (@(posedge clk) disable iff (srst) // RULE15
        $rose(status_reg[ST_DIVX]) |-> $past(divPrep))
        else $error("divide flag without divide");
    a_status_reset: assert property (@(posedge clk) // RULE13
        srst |=> (status_reg == STATUS_RESET))
        else $error("status not zero after reset");
    a_status_read: assert property (@(posedge clk) disable iff (srst) // RULE11
        (ce && stRead) |=> (dout_reg == $past(status_reg)) && doe_reg)
        else $error("status read not answered");
    a_srq_clear: assert property (@(posedge clk) disable iff (srst) // RULE21
        (ce && cmdTake) |=> !srq_reg)
        else $error("service request not cleared");
    a_result_pop: assert property (@(posedge clk) disable iff (srst) // RULE20
        (ce && eng_reg == ENG_WRITE) |=> (ptr_reg == $past(ptr_reg) - sizeCur))
        else $error("result not popped");
    a_zero_sign: assert property (@(posedge clk) disable iff (srst) // RULE16
        (ce && eng_reg == ENG_WRITE) |=> !(status_reg[ST_ZERO] && status_reg[ST_SIGN]))
        else $error("zero result marked negative");
    a_read_hold: assert property (@(posedge clk) disable iff (srst) // RULE9
        (ce && bus_reg == BUS_ACK && !rdS) |=> (dout_reg == $past(dout_reg)) && (doe_reg == $past(doe_reg)))
        else $error("read byte dropped while strobe low");
endmodule // fcp_host_port

// file: fcp_host_model.sv
`timescale 1ns/1ps
// behavioural host cpu: one strobe pulse per call, pins moved just after an edge
module fcp_host_model (
    input  wire logic       clk,
    input  wire logic       pauseN,
    input  wire logic       hostDataBusOe,
    input  wire logic [7:0] hostDataBusOut,
    output logic            csN,
    output logic            rdN,
    output logic            wrN,
    output logic            cmdData,
    output logic      [7:0] busDrive
);
    // idle pins; the bus starts at an arbitrary pattern
    initial begin
        csN = 1'b1;
        rdN = 1'b1;
        wrN = 1'b1;
        cmdData = 1'b0;
        busDrive = 8'h5a;
    end

    // strobe held until pause is sampled high, then released at the following edge
    task automatic xfer(input logic isRead, input logic cd, input logic [7:0] wData,
                        output logic [7:0] rData, output logic idleLow, output int waitCycles);
        waitCycles = 0;
        @(posedge clk);
        cmdData <= cd;
        csN <= 1'b0;
        busDrive <= wData;
        repeat (4) @(posedge clk);
        #1;
        idleLow = ~pauseN;
        @(posedge clk);
        if (isRead) rdN <= 1'b0;
        else wrN <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            waitCycles++;
        end while (pauseN !== 1'b1 && waitCycles < 3000);
        // an undriven bus would show the inverse of the device's byte
        rData = hostDataBusOe ? hostDataBusOut : ~hostDataBusOut;
        @(posedge clk);
        rdN <= 1'b1;
        wrN <= 1'b1;
        // released bus must not keep showing the old byte
        busDrive <= ~wData;
        repeat (3) @(posedge clk);
        csN <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
endmodule // fcp_host_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
    import fcp_pkg::*;
    logic       clk;
    logic       srst;
    logic       ce;
    logic       csN;
    logic       rdN;
    logic       wrN;
    logic       cmdData;
    logic [7:0] busDrive;
    logic [7:0] hostDataBusIn;
    logic [7:0] hostDataBusOut;
    logic       hostDataBusOe;
    logic       pauseN;
    logic       serviceRequest;
    int         failCount = 0;
    int         totalChecks = 0;
    // nos, tos, result and status for each arithmetic opcode
    localparam logic [6:0]  OPS  [8] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h29, 7'h2a, 7'h2b, 7'h2c};
    localparam logic [63:0] NOSV [8] = '{64'h0000_0000_3f80_0000, 64'h0000_0000_3f80_0000,
        64'h0000_0000_bfc0_0000, 64'h0000_0000_3f80_0000, 64'h3ff0_0000_0000_0000,
        64'h4000_0000_0000_0000, 64'h3ff8_0000_0000_0000, 64'h3ff8_0000_0000_0000};
    localparam logic [63:0] TOSV [8] = '{64'h0000_0000_3f80_0000, 64'h0000_0000_3f80_0000,
        64'h0000_0000_4040_0000, 64'h0000_0000_4000_0000, 64'h3ff0_0000_0000_0000,
        64'h3ff0_0000_0000_0000, 64'hbff8_0000_0000_0000, 64'hbff8_0000_0000_0000};
    localparam logic [63:0] RESV [8] = '{64'h0000_0000_4000_0000, 64'h0000_0000_0000_0000,
        64'h0000_0000_c090_0000, 64'h0000_0000_3f00_0000, 64'h4000_0000_0000_0000,
        64'h3ff0_0000_0000_0000, 64'hc002_0000_0000_0000, 64'hbff0_0000_0000_0000};
    localparam logic [7:0]  STV  [8] = '{8'h00, 8'h20, 8'h40, 8'h00, 8'h00, 8'h00, 8'h40, 8'h40};

    // the device drives the shared bus only while its enable is up
    assign hostDataBusIn = hostDataBusOe ? hostDataBusOut : busDrive;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    fcp_host_port i_fcp_host_port (.clk(clk), .srst(srst), .ce(ce), .csN(csN), .rdN(rdN), .wrN(wrN),
        .cmdData(cmdData), .hostDataBusIn(hostDataBusIn), .hostDataBusOut(hostDataBusOut),
        .hostDataBusOe(hostDataBusOe), .pauseN(pauseN), .serviceRequest(serviceRequest));
    fcp_host_model i_fcp_host_model (.clk(clk), .pauseN(pauseN), .hostDataBusOe(hostDataBusOe),
        .hostDataBusOut(hostDataBusOut), .csN(csN), .rdN(rdN), .wrN(wrN), .cmdData(cmdData),
        .busDrive(busDrive));

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        totalChecks++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrapUp;
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic xf(input logic isRead, input logic cd, input logic [7:0] wData,
                      output logic [7:0] rData, output int w);
        logic idleLow;
        i_fcp_host_model.xfer(isRead, cd, wData, rData, idleLow, w);
        check("pause low while selected", 64'h1, {63'h0, idleLow});
        check("pause acknowledged", 64'h1, {63'h0, (w < 3000)});
    endtask

    task automatic pushVal(input logic [63:0] v, input int n);
        logic [7:0] d;
        int         w;
        for (int i = 0; i < n; i++) xf(1'b0, 1'b0, v[8*i+:8], d, w);
    endtask

    task automatic popVal(input int n, output logic [63:0] v);
        logic [7:0] d;
        int         w;
        v = 64'h0;
        for (int i = 0; i < n; i++) begin
            xf(1'b1, 1'b0, 8'h00, d, w);
            v = {v[55:0], d};
        end
    endtask

    task automatic waitIdle(output logic [7:0] s);
        int w;
        for (int i = 0; i < 200; i++) begin
            xf(1'b1, 1'b1, 8'h00, s, w);
            if (s[ST_BUSY] === 1'b0) break;
        end
    endtask

    // every arithmetic opcode, service request enable alternating
    task automatic s_ops;
        logic [7:0]  s;
        logic [63:0] v;
        int          w;
        int          n;
        for (int i = 0; i < 8; i++) begin
            n = (i < 4) ? 4 : 8;
            pushVal(NOSV[i], n);
            pushVal(TOSV[i], n);
            xf(1'b0, 1'b1, {i[0], OPS[i]}, s, w);
            waitIdle(s);
            check("status", {56'h0, STV[i]}, {56'h0, s});
            check("service request", {63'h0, i[0]}, {63'h0, serviceRequest});
            popVal(n, v);
            check("result", RESV[i], v);
        end
    endtask

    // a command written during a long divide is held off until it ends
    task automatic s_queue;
        logic [7:0]  s;
        logic [63:0] v;
        int          w;
        pushVal(64'h0000_0000_3f80_0000, 4);
        pushVal(64'h0000_0000_4000_0000, 4);
        xf(1'b0, 1'b1, 8'h04, s, w);
        xf(1'b1, 1'b1, 8'h00, s, w);
        check("busy during divide", 64'h1, {63'h0, s[ST_BUSY]});
        xf(1'b0, 1'b1, 8'h00, s, w);
        check("queued command held", 64'h1, {63'h0, (w > 20)});
        waitIdle(s);
        check("status after clear", 64'h0, {56'h0, s});
        popVal(4, v);
        check("divide result", 64'h0000_0000_3f00_0000, v);
    endtask

    // exponent overflow on multiply, underflow on divide
    task automatic s_range;
        logic [7:0]  s;
        logic [63:0] v;
        int          w;
        for (int i = 0; i < 2; i++) begin
            pushVal(i ? 64'h0000_0000_0d80_0000 : 64'h0000_0000_7180_0000, 4);
            pushVal(64'h0000_0000_7180_0000, 4);
            xf(1'b0, 1'b1, i ? 8'h04 : 8'h03, s, w);
            waitIdle(s);
            check("range status", i ? 64'h04 : 64'h02, {56'h0, s});
            popVal(4, v);
        end
    endtask

    // clock enable low freezes a running divide, so it is still busy after
    task automatic s_freeze;
        logic [7:0]  s;
        logic [63:0] v;
        int          w;
        pushVal(64'h0000_0000_3f80_0000, 4);
        pushVal(64'h0000_0000_4000_0000, 4);
        xf(1'b0, 1'b1, 8'h04, s, w);
        ce <= 1'b0;
        repeat (200) @(posedge clk);
        ce <= 1'b1;
        xf(1'b1, 1'b1, 8'h00, s, w);
        check("busy after freeze", 64'h1, {63'h0, s[ST_BUSY]});
        waitIdle(s);
        popVal(4, v);
        check("divide after freeze", 64'h0000_0000_3f00_0000, v);
    endtask

    // divide by zero flags the exception and leaves the stack alone
    task automatic s_divzero;
        logic [7:0]  s;
        logic [63:0] v;
        int          w;
        pushVal(64'h0000_0000_3f80_0000, 4);
        pushVal(64'h0000_0000_0000_0000, 4);
        xf(1'b0, 1'b1, 8'h04, s, w);
        waitIdle(s);
        check("divide exception", 64'h08, {56'h0, s});
        popVal(8, v);
        check("stack kept", 64'h0000_0000_3f80_0000, v);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        xf(1'b1, 1'b1, 8'h00, s, w);
        check("status after reset", 64'h0, {56'h0, s});
    endtask

    // overfill the stack, then pop past its size
    task automatic s_wrap;
        logic [63:0] v;
        pushVal(64'h0807_0605_0403_0201, 8);
        pushVal(64'h100f_0e0d_0c0b_0a09, 8);
        pushVal(64'h0000_0000_1413_1211, 4);
        for (int k = 0; k < 20; k++) begin
            popVal(1, v);
            check("stack byte", 64'd20 - 64'(k % 16), v);
        end
    endtask

    initial begin
        logic [7:0] s;
        int         w;
        ce = 1'b1;
        srst = 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        xf(1'b1, 1'b1, 8'h00, s, w);
        check("status at start", 64'h0, {56'h0, s});
        s_ops();
        s_queue();
        s_range();
        s_freeze();
        s_divzero();
        s_wrap();
        wrapUp();
    end

    // cuts a hang short well beyond the expected run length
    initial begin
        repeat (80000) @(posedge clk);
        failCount++;
        $display("[FAIL] watchdog expected finish seen timeout");
        wrapUp();
    end
endmodule // tb
